// ---- rtl/reclose_defs.svh ----
`ifndef RECLOSE_DEFS_SVH
`define RECLOSE_DEFS_SVH

// trip sequence counter
`define SEQ_W 3
`define SEQ_ZERO 3'h0
`define SEQ_MAX 3'h7
`define SEQ_STATES 5
// per-trip blocking settings cover trips one to five
`define TRIP_SLOTS 5
// system check condition inputs, bit 0 is the synchronism result
`define SYSCHK_W 4
`define SYSCHK_SYNC_BIT 0

`endif

// ---- rtl/reclose_pkg.sv ----
package reclose_pkg;

  typedef enum logic [1:0] {
    MODE_NON_AUTO = 2'h0,
    MODE_AUTO = 2'h1,
    MODE_LIVE_LINE = 2'h2
  } op_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CYCLE = 3'h2,
    ST_LOCKOUT = 3'h4
  } cycle_state_t;

  // events and levels from the reclose core state machine
  typedef struct packed {
    logic cycle_start;
    logic prot_op;
    logic fault_trip;
    logic dead_time_expired;
    logic checks_active;
    logic syscheck_time_expired;
    logic healthy_time_expired;
    logic close_issue;
    logic breaker_closed;
    logic breaker_trip;
    logic reclaim_active;
    logic reclaim_expired;
    logic lockout_trigger;
    logic manual_close_inhibit;
    logic cause_present;
  } core_ev_t;

  // configuration settings
  typedef struct packed {
    logic [4:0] trip_main_block;
    logic [4:0] trip_sens_block;
    logic [3:0] syschk_enable;
    logic lockout_self_reset;
    logic reset_on_non_auto;
  } reclose_cfg_t;

endpackage : reclose_pkg

// ---- rtl/autoreclose_status_outputs.sv ----
`timescale 1ns/1ps
`include "reclose_defs.svh"

// Behaviour
// - cycle_active high from protection to reclaim/lockout
// - delayed_cycle_active rises with cycle_active
// - delayed_close_done clears delayed_cycle_active early
// - trip counter increments per trip, zero after cycle
// - five decoded counter status outputs, zero to four
// - reclose_success set on reclose, cleared trip/reset
// - reclose_in_service high only in auto mode
// - main_inst_block per trip main settings
// - sens_earth_inst_block per trip sensitive settings
// - reclose_checking while system checks run
// - dead_time_running is checking and dead_time_permit
// - dead_time_done until reclaim end, protection, initiation
// - reclose_sync_ok when either sync module ok
// - reclose_syschk_ok when any enabled check ok
// - auto_close_cmd from close issue to breaker closed
// - prot_lockout_flag on protection lockout, inhibit/any mode but auto
// - lockout_reset_alarm in non-auto when reset selected
// - reclaim_running follows the reclaim timer
// - reclaim_done single-cycle pulse at reclaim expiry
// - latched syscheck_fail_alarm plus lockout, manual clear
// - latched breaker_unhealthy_alarm plus lockout, manual clear
// - lockout_alarm in lockout, auto or manual reset
// - lockout reset only once causes are gone
module autoreclose_status_outputs
  import reclose_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire core_ev_t ev_i,
  input wire reclose_cfg_t cfg_i,
  input wire op_mode_t mode_i,
  input wire logic delayed_close_done_i,
  input wire logic dead_time_permit_i,
  input wire logic breaker_healthy_i,
  input wire logic sync_check_module_one_i,
  input wire logic sync_check_module_two_i,
  input wire logic [`SYSCHK_W-1:0] syschk_cond_i,
  input wire logic lockout_reset_i,
  output logic cycle_active_o,
  output logic delayed_cycle_active_o,
  output logic [`SEQ_STATES-1:0] seq_status_o,
  output logic reclose_success_o,
  output logic reclose_in_service_o,
  output logic main_inst_block_o,
  output logic sens_earth_inst_block_o,
  output logic reclose_checking_o,
  output logic dead_time_running_o,
  output logic dead_time_done_o,
  output logic reclose_sync_ok_o,
  output logic reclose_syschk_ok_o,
  output logic auto_close_cmd_o,
  output logic prot_lockout_flag_o,
  output logic lockout_reset_alarm_o,
  output logic reclaim_running_o,
  output logic reclaim_done_o,
  output logic syscheck_fail_alarm_o,
  output logic breaker_unhealthy_alarm_o,
  output logic lockout_alarm_o
);

  cycle_state_t state;
  cycle_state_t next_state;
  logic [`SEQ_W-1:0] seq_count;
  logic sync_now;
  logic syschk_now;
  logic syschk_fail;
  logic healthy_fail;
  logic enter_lockout;
  logic clear_allowed;
  logic manual_clear;
  logic lockout_clear;
  logic count_trip;

  // combinational check results
  always_comb begin
    sync_now = sync_check_module_one_i | sync_check_module_two_i;
    syschk_now = |(syschk_cond_i & cfg_i.syschk_enable);
  end

  always_comb begin
    syschk_fail = ev_i.syscheck_time_expired & ~syschk_now;
    healthy_fail = ev_i.healthy_time_expired & ~breaker_healthy_i;
    enter_lockout = ev_i.lockout_trigger | syschk_fail | healthy_fail;
    clear_allowed = ~ev_i.cause_present;
    manual_clear = lockout_reset_i & clear_allowed;
    lockout_clear = clear_allowed & (lockout_reset_i | cfg_i.lockout_self_reset |
                    (cfg_i.reset_on_non_auto & (mode_i == MODE_NON_AUTO)));
  end

  // cycle state machine
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (enter_lockout) begin
          next_state = ST_LOCKOUT;
        end else if (ev_i.cycle_start | ev_i.prot_op & (mode_i == MODE_AUTO)) begin
          next_state = ST_CYCLE;
        end
      end
      ST_CYCLE: begin
        if (enter_lockout) begin
          next_state = ST_LOCKOUT;
        end else if (ev_i.reclaim_expired) begin
          next_state = ST_IDLE;
        end
      end
      ST_LOCKOUT: begin
        if (lockout_clear & ~enter_lockout) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // cycle activity indications
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cycle_active_o <= 1'b0;
      delayed_cycle_active_o <= 1'b0;
      lockout_alarm_o <= 1'b0;
    end else if (ce_i) begin
      cycle_active_o <= (next_state == ST_CYCLE);
      lockout_alarm_o <= (next_state == ST_LOCKOUT);
      if (next_state != ST_CYCLE) begin
        delayed_cycle_active_o <= 1'b0;
      end else if (state != ST_CYCLE) begin
        delayed_cycle_active_o <= 1'b1;
      end else if (delayed_close_done_i) begin
        delayed_cycle_active_o <= 1'b0;
      end
    end
  end

  chk_delayed_follows_cycle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(cycle_active_o) |-> delayed_cycle_active_o)
    else $error("delayed cycle flag did not rise with cycle flag");

  chk_delayed_inside_cycle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    delayed_cycle_active_o |-> cycle_active_o)
    else $error("delayed cycle flag outside a cycle");

  chk_lockout_exclusive: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && state == ST_LOCKOUT && !lockout_clear |=> lockout_alarm_o && !cycle_active_o)
    else $error("lockout alarm lost while lockout held");

  chk_reset_needs_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && state == ST_LOCKOUT && ev_i.cause_present |=> state == ST_LOCKOUT)
    else $error("lockout left while cause still present");

  // trip sequence counter
  always_comb begin
    count_trip = ev_i.fault_trip & (next_state == ST_CYCLE) & (seq_count != `SEQ_MAX);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_count <= `SEQ_ZERO;
    end else if (ce_i) begin
      if (next_state != ST_CYCLE) begin
        seq_count <= `SEQ_ZERO;
      end else if (count_trip) begin
        seq_count <= seq_count + `SEQ_W'(1);
      end
    end
  end

  chk_counter_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && count_trip |=> seq_count == $past(seq_count) + `SEQ_W'(1))
    else $error("sequence counter did not step by one");

  // decoded counter status, registered from the next count
  generate
    for (genvar i = 0; i < `SEQ_STATES; i++) begin : g_seq_status
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          seq_status_o[i] <= 1'b0;
        end else if (ce_i) begin
          if (next_state != ST_CYCLE) begin
            seq_status_o[i] <= (i == 0);
          end else if (count_trip) begin
            seq_status_o[i] <= (seq_count + `SEQ_W'(1) == `SEQ_W'(i));
          end else begin
            seq_status_o[i] <= (seq_count == `SEQ_W'(i));
          end
        end
      end
    end
  endgenerate

  chk_status_decode: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i ##1 1'b1 |-> seq_status_o == ((seq_count < `SEQ_W'(`SEQ_STATES)) ?
      (`SEQ_STATES'(1) << seq_count) : `SEQ_STATES'(0)))
    else $error("sequence status does not match counter");

  // instantaneous stage blocking for the coming trip
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      main_inst_block_o <= 1'b0;
      sens_earth_inst_block_o <= 1'b0;
    end else if (ce_i) begin
      if (mode_i == MODE_LIVE_LINE || seq_count >= `SEQ_W'(`TRIP_SLOTS)) begin
        main_inst_block_o <= 1'b0;
        sens_earth_inst_block_o <= 1'b0;
      end else begin
        main_inst_block_o <= cfg_i.trip_main_block[seq_count];
        sens_earth_inst_block_o <= cfg_i.trip_sens_block[seq_count];
      end
    end
  end

  chk_main_block_sel: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && mode_i != MODE_LIVE_LINE && seq_count == `SEQ_W'(1) |=>
      main_inst_block_o == $past(cfg_i.trip_main_block[1]))
    else $error("main block does not follow trip two setting");

  chk_sens_block_sel: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && mode_i != MODE_LIVE_LINE && seq_count == `SEQ_ZERO |=>
      sens_earth_inst_block_o == $past(cfg_i.trip_sens_block[0]))
    else $error("sensitive block does not follow trip one setting");

  // mode and check indications
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reclose_in_service_o <= 1'b0;
      lockout_reset_alarm_o <= 1'b0;
      reclose_checking_o <= 1'b0;
      dead_time_running_o <= 1'b0;
      reclose_sync_ok_o <= 1'b0;
      reclose_syschk_ok_o <= 1'b0;
      reclaim_running_o <= 1'b0;
      reclaim_done_o <= 1'b0;
    end else if (ce_i) begin
      reclose_in_service_o <= (mode_i == MODE_AUTO);
      lockout_reset_alarm_o <= (mode_i == MODE_NON_AUTO) & cfg_i.reset_on_non_auto;
      reclose_checking_o <= ev_i.checks_active;
      dead_time_running_o <= ev_i.checks_active & dead_time_permit_i;
      reclose_sync_ok_o <= sync_now;
      reclose_syschk_ok_o <= syschk_now;
      reclaim_running_o <= ev_i.reclaim_active;
      reclaim_done_o <= ev_i.reclaim_expired & ~reclaim_done_o;
    end
  end

  chk_dead_run_and: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    dead_time_running_o |-> reclose_checking_o)
    else $error("dead time running without system checks");

  chk_service_mode: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && mode_i != MODE_AUTO |=> !reclose_in_service_o)
    else $error("in service outside auto mode");

  chk_reclaim_pulse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reclaim_done_o && ce_i |=> !reclaim_done_o)
    else $error("reclaim done stretched");

  // latched cycle events, the setting event wins over a clear
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dead_time_done_o <= 1'b0;
    end else if (ce_i) begin
      if (ev_i.dead_time_expired) begin
        dead_time_done_o <= 1'b1;
      end else if (ev_i.reclaim_expired | ev_i.prot_op | ev_i.cycle_start) begin
        dead_time_done_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      auto_close_cmd_o <= 1'b0;
    end else if (ce_i) begin
      if (ev_i.close_issue) begin
        auto_close_cmd_o <= 1'b1;
      end else if (ev_i.breaker_closed) begin
        auto_close_cmd_o <= 1'b0;
      end
    end
  end

  chk_close_holds: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    auto_close_cmd_o && !ev_i.breaker_closed |=> auto_close_cmd_o)
    else $error("close command dropped before breaker closed");

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reclose_success_o <= 1'b0;
    end else if (ce_i) begin
      if (state == ST_CYCLE && ev_i.reclaim_expired && ev_i.breaker_closed && !enter_lockout) begin
        reclose_success_o <= 1'b1;
      end else if (ev_i.breaker_trip | (state == ST_LOCKOUT & lockout_clear)) begin
        reclose_success_o <= 1'b0;
      end
    end
  end

  chk_success_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && ev_i.breaker_trip && !(state == ST_CYCLE && ev_i.reclaim_expired) |=> !reclose_success_o)
    else $error("success flag not cleared by breaker trip");

  // lockout related latches
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prot_lockout_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (ev_i.lockout_trigger & ev_i.prot_op & (ev_i.manual_close_inhibit | mode_i != MODE_AUTO)) begin
        prot_lockout_flag_o <= 1'b1;
      end else if (state == ST_LOCKOUT & lockout_clear) begin
        prot_lockout_flag_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      syscheck_fail_alarm_o <= 1'b0;
      breaker_unhealthy_alarm_o <= 1'b0;
    end else if (ce_i) begin
      if (syschk_fail) begin
        syscheck_fail_alarm_o <= 1'b1;
      end else if (manual_clear) begin
        syscheck_fail_alarm_o <= 1'b0;
      end
      if (healthy_fail) begin
        breaker_unhealthy_alarm_o <= 1'b1;
      end else if (manual_clear) begin
        breaker_unhealthy_alarm_o <= 1'b0;
      end
    end
  end

  chk_syschk_latch: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && syschk_fail |=> syscheck_fail_alarm_o && lockout_alarm_o)
    else $error("system check failure not latched into lockout");

  chk_unhealthy_manual: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    breaker_unhealthy_alarm_o && !lockout_reset_i |=> breaker_unhealthy_alarm_o)
    else $error("breaker unhealthy alarm cleared without manual reset");

  chk_prot_lockout_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && ev_i.lockout_trigger && ev_i.prot_op && mode_i == MODE_NON_AUTO |=> prot_lockout_flag_o)
    else $error("protection lockout flag not set in non-auto mode");

endmodule : autoreclose_status_outputs

// ---- bench/breaker_model.sv ----
`timescale 1ns/1ps
module breaker_model #(
  parameter int CLOSE_DELAY = 3
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic close_cmd_i,
  input wire logic trip_i,
  output logic closed_o
);
  int cnt;
  // breaker closes some cycles after the close command, opens on trip
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 0;
      closed_o <= 1'b0;
    end else if (trip_i) begin
      cnt <= 0;
      closed_o <= 1'b0;
    end else if (close_cmd_i && !closed_o) begin
      cnt <= cnt + 1;
      if (cnt == CLOSE_DELAY - 1) begin
        closed_o <= 1'b1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule : breaker_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import reclose_pkg::*;
  logic sys_clk_i, reset_i, ce;
  core_ev_t ev, ev_w;
  reclose_cfg_t cfg;
  op_mode_t mode;
  logic dcd, dtp, hlth, s1, s2, lrst, brk;
  logic [3:0] cond;
  logic ca, dca, succ, insv, mb, sb, chk, dtr, dtd, syok, scok, acc, plf, lra, rr, rd, sfa, bua, loa;
  logic [4:0] seq;
  int fail_count, num_checks;

  always_comb begin
    ev_w = ev;
    ev_w.breaker_closed = brk;
  end

  breaker_model #(.CLOSE_DELAY(3)) partner (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .close_cmd_i(acc), .trip_i(ev.breaker_trip), .closed_o(brk));

  autoreclose_status_outputs DUT (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(ce), .ev_i(ev_w), .cfg_i(cfg), .mode_i(mode),
    .delayed_close_done_i(dcd), .dead_time_permit_i(dtp), .breaker_healthy_i(hlth),
    .sync_check_module_one_i(s1), .sync_check_module_two_i(s2), .syschk_cond_i(cond),
    .lockout_reset_i(lrst), .cycle_active_o(ca), .delayed_cycle_active_o(dca), .seq_status_o(seq),
    .reclose_success_o(succ), .reclose_in_service_o(insv), .main_inst_block_o(mb),
    .sens_earth_inst_block_o(sb), .reclose_checking_o(chk), .dead_time_running_o(dtr),
    .dead_time_done_o(dtd), .reclose_sync_ok_o(syok), .reclose_syschk_ok_o(scok),
    .auto_close_cmd_o(acc), .prot_lockout_flag_o(plf), .lockout_reset_alarm_o(lra),
    .reclaim_running_o(rr), .reclaim_done_o(rd), .syscheck_fail_alarm_o(sfa),
    .breaker_unhealthy_alarm_o(bua), .lockout_alarm_o(loa));

  task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick

  task automatic results();
    $display("checks=%0d failures=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic t_cycle();
    int i;
    cfg.trip_main_block = 5'h0a;
    cfg.trip_sens_block = 5'h05;
    ev.cycle_start = 1'b1;
    ev.fault_trip = 1'b1;
    tick(1);
    ev.cycle_start = 1'b0;
    ev.fault_trip = 1'b0;
    cmp({ca, dca}, 2'h3);
    cmp(seq, 5'h02);
    tick(1);
    cmp({mb, sb}, {cfg.trip_main_block[1], cfg.trip_sens_block[1]});
    for (i = 2; i <= 5; i++) begin
      ev.fault_trip = 1'b1;
      tick(1);
      ev.fault_trip = 1'b0;
      cmp(seq, (i < 5) ? (5'h01 << i) : 5'h00);
      tick(1);
      cmp({mb, sb}, (i < 5) ? {cfg.trip_main_block[i], cfg.trip_sens_block[i]} : 2'h0);
    end
    ev.dead_time_expired = 1'b1;
    tick(1);
    ev.dead_time_expired = 1'b0;
    cmp(dtd, 1'b1);
    ev.close_issue = 1'b1;
    tick(1);
    ev.close_issue = 1'b0;
    cmp(acc, 1'b1);
    i = 0;
    while (acc === 1'b1 && i < 20) begin
      tick(1);
      i++;
    end
    if (i >= 20) begin
      cmp(acc, 5'h00);
      results();
    end
    cmp({acc, brk, dtd}, 3'h3);
    dcd = 1'b1;
    tick(1);
    dcd = 1'b0;
    cmp({ca, dca}, 2'h2);
    ev.reclaim_active = 1'b1;
    tick(1);
    cmp(rr, 1'b1);
    ev.reclaim_expired = 1'b1;
    ev.reclaim_active = 1'b0;
    tick(1);
    ev.reclaim_expired = 1'b0;
    cmp({ca, succ, rd, dtd, rr}, 5'h0c);
    cmp(seq, 5'h01);
    tick(1);
    cmp({rd, succ}, 2'h1);
    ev.breaker_trip = 1'b1;
    tick(1);
    ev.breaker_trip = 1'b0;
    cmp(succ, 1'b0);
  endtask : t_cycle

  task automatic t_levels();
    int i;
    op_mode_t m[3];
    m = '{MODE_AUTO, MODE_LIVE_LINE, MODE_NON_AUTO};
    ce = 1'b0;
    ev.checks_active = 1'b1;
    dtp = 1'b0;
    tick(1);
    cmp({chk, dtr}, 2'h0);
    ce = 1'b1;
    tick(1);
    cmp({chk, dtr}, 2'h2);
    dtp = 1'b1;
    tick(1);
    cmp({chk, dtr}, 2'h3);
    ev.checks_active = 1'b0;
    tick(1);
    cmp({chk, dtr}, 2'h0);
    for (i = 0; i < 4; i++) begin
      {s2, s1} = i[1:0];
      tick(1);
      cmp(syok, s1 | s2);
    end
    cfg.syschk_enable = 4'h5;
    cond = 4'h2;
    tick(1);
    cmp(scok, 1'b0);
    cond = 4'h4;
    tick(1);
    cmp(scok, 1'b1);
    for (i = 0; i < 3; i++) begin
      mode = m[i];
      tick(1);
      cmp(insv, m[i] == MODE_AUTO);
      cmp(sb, cfg.trip_sens_block[0] & (m[i] != MODE_LIVE_LINE));
    end
  endtask : t_levels

  task automatic t_lockout();
    ev.prot_op = 1'b1;
    ev.lockout_trigger = 1'b1;
    ev.cause_present = 1'b1;
    tick(1);
    ev.prot_op = 1'b0;
    ev.lockout_trigger = 1'b0;
    cmp({loa, plf}, 2'h3);
    lrst = 1'b1;
    tick(2);
    cmp(loa, 1'b1);
    ev.cause_present = 1'b0;
    tick(1);
    cmp({loa, plf}, 2'h0);
    lrst = 1'b0;
    cfg.reset_on_non_auto = 1'b1;
    tick(1);
    cmp(lra, 1'b1);
    mode = MODE_AUTO;
    tick(1);
    cmp(lra, 1'b0);
    cfg.reset_on_non_auto = 1'b0;
  endtask : t_lockout

  task automatic t_alarms();
    ev.cycle_start = 1'b1;
    ev.dead_time_expired = 1'b1;
    tick(1);
    ev.cycle_start = 1'b0;
    ev.dead_time_expired = 1'b0;
    ev.prot_op = 1'b1;
    tick(1);
    ev.prot_op = 1'b0;
    cmp({ca, dtd}, 2'h2);
    cond = 4'h0;
    hlth = 1'b0;
    ev.cause_present = 1'b1;
    ev.syscheck_time_expired = 1'b1;
    ev.healthy_time_expired = 1'b1;
    tick(1);
    ev.syscheck_time_expired = 1'b0;
    ev.healthy_time_expired = 1'b0;
    cmp({sfa, bua, loa}, 3'h7);
    cfg.lockout_self_reset = 1'b1;
    ev.cause_present = 1'b0;
    tick(2);
    cmp({sfa, bua, loa}, 3'h6);
    lrst = 1'b1;
    tick(1);
    lrst = 1'b0;
    cmp({sfa, bua}, 2'h0);
  endtask : t_alarms

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    reset_i = 1'b1;
    ce = 1'b1;
    ev = '0;
    cfg = '0;
    mode = MODE_AUTO;
    dcd = 1'b0;
    dtp = 1'b1;
    hlth = 1'b1;
    s1 = 1'b0;
    s2 = 1'b0;
    cond = 4'h0;
    lrst = 1'b0;
    tick(10);
    cmp(seq, 5'h00);
    cmp({ca, dca, loa, acc, rd}, 5'h00);
    reset_i = 1'b0;
    tick(1);
    cmp(seq, 5'h01);
    t_cycle();
    t_levels();
    t_lockout();
    t_alarms();
    results();
  end
endmodule : tb_top
